/* core/sspb_bank.sv */
// Special-setup parameter bank with APB slave and derived drive signals
// What this block does
// - Display-select value chooses the data item shown on the LED panel.
// - Station alias shown after power-up for the set time in 100 ms units.
// - Settings 0 to 6 give a fixed 600 ms alias display time.
// - Torque-limit output: 0 includes torque command, 1 excludes it.
// - Power-off warning after set interruption time; 0-9 and 2000 disable.
// - Warning time in 1 ms units, resolved to 2 ms steps.
// - Consecutive torque saturations counted; error when count hits limit.
// - Saturation limit zero disables the protection error.
// - Extended setup two bit 14 picks deviation reference; others zero.
// - Setup three bit 0: hold or clear general output on shutdown.
// - Link counts as established only past the pre-operational state.
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
module sspb_bank
  import sspb_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P  = TICK_CYCLES,
  parameter logic [15:0] RST_LED_SEL    = 16'h0000,
  parameter logic [15:0] RST_ALIAS_TIME = 16'h0000,
  parameter logic [15:0] RST_TQ_JUDGE   = 16'h0000,
  parameter logic [15:0] RST_WARN_TIME  = 16'h0000,
  parameter logic [15:0] RST_SAT_LIMIT  = 16'h0000
) (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rstn,
  // APB slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [11:0]    paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  // Drive status and fieldbus link
  input  wire sspb_drive_type drive,
  input  wire sspb_link_type  link,
  // Derived outputs
  output logic      [14:0]    led_display_item,
  output logic                alias_display_on,
  output logic                torque_limit_active,
  output logic                power_off_warning,
  output logic                torque_sat_error,
  output logic                deviation_before_filter,
  output logic                fieldbus_general_output,
  output logic                irq
);

  // At least one bit, so a divide-by-one tick still builds
  localparam int unsigned TICK_W = (TICK_CYCLES_P > 1) ?
                                   $clog2(TICK_CYCLES_P) : 1;

  logic [15:0]      led_display_select;
  logic [15:0]      powerup_alias_display_time;
  logic [15:0]      torque_limit_output_judge;
  logic [15:0]      main_power_off_warn_time;
  logic [15:0]      torque_saturation_count_limit;
  logic [15:0]      comm_extended_setup_two;
  logic [15:0]      comm_extended_setup_three;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] events;
  logic [TICK_W-1:0] tick_cnt;
  logic             ms_tick;
  logic [16:0]      alias_ms;
  logic [16:0]      alias_target;
  logic [10:0]      warn_ms;
  logic [10:0]      warn_next_ms;
  logic [10:0]      warn_limit_ms;
  logic             warn_enabled;
  logic [15:0]      sat_cnt;
  logic [15:0]      next_sat_cnt;
  logic             established;
  logic             access;
  logic             wr_en;
  logic             rd_en;
  logic [31:0]      rd_word;
  logic             rd_hit;
  logic             sat_clear;
  logic             status_rd;

  // Fixed value of a reserved parameter slot
  function automatic logic [15:0] rsvd_value(input logic [11:0] a);
    if (a == OFF_RSVD_09) begin
      return RSVD_09_VAL;
    end else if (a == OFF_RSVD_10) begin
      return RSVD_10_VAL;
    end
    return RSVD_ZERO_VAL;
  endfunction

  function automatic logic is_rsvd(input logic [11:0] a);
    return (a >= OFF_RSVD_FIRST) && (a <= OFF_RSVD_LAST) &&
           (a[1:0] == 2'b00);
  endfunction

  // Bus handshake: one wait state, answer in the second access cycle
  // The wait state keeps the decode off the pready path
  assign access = psel & penable & ~pready;
  assign wr_en  = access & pwrite;
  assign rd_en  = access & ~pwrite;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (is_rsvd(paddr)) begin
      rd_word = {16'h0000, rsvd_value(paddr)};
    end else begin
      unique case (paddr)
        OFF_LED_SEL:    rd_word = {16'h0000, led_display_select};
        OFF_ALIAS_TIME: rd_word = {16'h0000, powerup_alias_display_time};
        OFF_TQ_JUDGE:   rd_word = {16'h0000, torque_limit_output_judge};
        OFF_WARN_TIME:  rd_word = {16'h0000, main_power_off_warn_time};
        OFF_SAT_LIMIT:  rd_word = {16'h0000, torque_saturation_count_limit};
        OFF_EXT_ONE:    rd_word = 32'h0000_0000;
        OFF_EXT_TWO:    rd_word = {16'h0000, comm_extended_setup_two};
        OFF_EXT_THREE:  rd_word = {16'h0000, comm_extended_setup_three};
        OFF_IRQ_STATUS: rd_word = {29'h0, irq_status};
        OFF_IRQ_MASK:   rd_word = {29'h0, irq_mask};
        OFF_CONTROL:    rd_word = 32'h0000_0000;
        OFF_STATE:      rd_word = {28'h0, established, torque_sat_error,
                                   power_off_warning, alias_display_on};
        default:        rd_hit  = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access & ~rd_hit;
      if (rd_en) begin
        prdata <= rd_hit ? rd_word : 32'h0000_0000;
      end
    end
  end

  // Parameter storage; writes to reserved slots are dropped
  // Reserved bits are not stored, so they always read back fixed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      led_display_select            <= RST_LED_SEL;
      powerup_alias_display_time    <= RST_ALIAS_TIME;
      torque_limit_output_judge     <= RST_TQ_JUDGE;
      main_power_off_warn_time      <= RST_WARN_TIME;
      torque_saturation_count_limit <= RST_SAT_LIMIT;
      comm_extended_setup_two       <= 16'h0000;
      comm_extended_setup_three     <= EXT_THREE_FIXED;
      irq_mask                      <= '0;
    end else if (wr_en && rd_hit) begin
      unique case (paddr)
        OFF_LED_SEL:    led_display_select <= pwdata[15:0];
        OFF_ALIAS_TIME: powerup_alias_display_time <= pwdata[15:0];
        OFF_TQ_JUDGE:   torque_limit_output_judge <= pwdata[15:0];
        OFF_WARN_TIME:  main_power_off_warn_time <= pwdata[15:0];
        OFF_SAT_LIMIT:  torque_saturation_count_limit <= pwdata[15:0];
        OFF_EXT_TWO: begin
          comm_extended_setup_two <= 16'h0000;
          comm_extended_setup_two[EXT_TWO_DEV_BIT] <=
            pwdata[EXT_TWO_DEV_BIT];
        end
        OFF_EXT_THREE: begin
          comm_extended_setup_three <= EXT_THREE_FIXED;
          comm_extended_setup_three[EXT_THREE_SHUT_BIT] <=
            pwdata[EXT_THREE_SHUT_BIT];
        end
        OFF_IRQ_MASK:   irq_mask <= pwdata[IRQ_W-1:0];
        default:        ;
      endcase
    end
  end

  // Strobes decoded from the first access cycle only
  assign sat_clear = wr_en && (paddr == OFF_CONTROL) &&
                     pwdata[CTRL_SAT_CLR_BIT];
  assign status_rd = rd_en && (paddr == OFF_IRQ_STATUS);

  // Millisecond tick
  // Timers share it, so the warning timer may end up to one tick early; the alias timer starts with it at reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt <= '0;
      ms_tick  <= 1'b0;
    end else if (tick_cnt == TICK_W'(TICK_CYCLES_P - 1)) begin
      tick_cnt <= '0;
      ms_tick  <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + TICK_W'(1);
      ms_tick  <= 1'b0;
    end
  end

  always_comb begin
    logic [10:0] units;
    units = 11'(powerup_alias_display_time);
    // A negative setting ends the alias display at the next ms tick
    if (powerup_alias_display_time[15]) begin
      units = 11'h000;
    end else if (powerup_alias_display_time <= 16'(ALIAS_MIN_SET)) begin
      units = 11'(ALIAS_MIN_SET);
    end else if (powerup_alias_display_time > 16'(ALIAS_MAX_SET)) begin
      units = 11'(ALIAS_MAX_SET);
    end
    alias_target = 17'(units) * 17'(ALIAS_UNIT_MS);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alias_ms         <= '0;
      alias_display_on <= 1'b1;
    end else if (alias_display_on && ms_tick) begin
      if (alias_ms + 17'h1 >= alias_target) begin
        alias_display_on <= 1'b0;
      end
      alias_ms <= alias_ms + 17'h1;
    end
  end

  assign warn_enabled = (main_power_off_warn_time >= WARN_MIN_SET) &&
                        (main_power_off_warn_time < WARN_OFF_SET);
  assign warn_next_ms = warn_ms + 11'h001;
  // Threshold rounded down to the 2 ms step
  assign warn_limit_ms = {main_power_off_warn_time[10:1], 1'b0};

  // Power-off warning timer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      warn_ms           <= '0;
      power_off_warning <= 1'b0;
    end else if (!drive.main_power_lost || !warn_enabled) begin
      warn_ms           <= '0;
      power_off_warning <= 1'b0;
    end else if (ms_tick && !power_off_warning) begin
      warn_ms <= warn_next_ms;
      if (warn_next_ms >= warn_limit_ms) begin
        power_off_warning <= 1'b1;
      end
    end
  end

  // Consecutive saturation count
  // Saturates rather than wrapping, so a long run cannot re-arm
  assign next_sat_cnt = (sat_cnt == 16'hFFFF) ? sat_cnt : sat_cnt + 16'h1;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sat_cnt          <= '0;
      torque_sat_error <= 1'b0;
    end else begin
      if (drive.sat_strobe) begin
        sat_cnt <= drive.saturated ? next_sat_cnt : 16'h0000;
      end
      // Zero limit disables; set wins over clear
      if (drive.sat_strobe && drive.saturated &&
          torque_saturation_count_limit != 16'h0000 &&
          next_sat_cnt >= torque_saturation_count_limit) begin
        torque_sat_error <= 1'b1;
      end else if (sat_clear) begin
        torque_sat_error <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      torque_limit_active <= 1'b0;
    end else begin
      torque_limit_active <= drive.torque_mode &
        (torque_limit_output_judge[0] ? drive.limit_excl_cmd
                                      : drive.limit_incl_cmd);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      led_display_item        <= '0;
      deviation_before_filter <= 1'b0;
    end else begin
      led_display_item        <= led_display_select[14:0];
      deviation_before_filter <= comm_extended_setup_two[EXT_TWO_DEV_BIT];
    end
  end

  // Established past pre-operational
  // Kept through a shutdown; only a fresh init clears it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      established <= 1'b0;
    end else if (link.state == SSPB_SAFE_OPERATIONAL ||
                 link.state == SSPB_OPERATIONAL) begin
      established <= 1'b1;
    end else if (link.state == SSPB_INIT && !link.link_down) begin
      established <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fieldbus_general_output <= 1'b0;
    end else if (link.link_down && established) begin
      if (comm_extended_setup_three[EXT_THREE_SHUT_BIT]) begin
        fieldbus_general_output <= 1'b0;
      end
    end else begin
      fieldbus_general_output <= link.gen_out_cmd;
    end
  end

  // Interrupt events are rising edges of warning and saturation error, and the fall of alias display
  // Delay flops reset to each source's own reset level,
  // so no false event follows reset
  logic alias_on_q;
  logic warn_q;
  logic sat_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alias_on_q <= 1'b1;
      warn_q     <= 1'b0;
      sat_q      <= 1'b0;
    end else begin
      alias_on_q <= alias_display_on;
      warn_q     <= power_off_warning;
      sat_q      <= torque_sat_error;
    end
  end

  always_comb begin
    events                 = '0;
    events[IRQ_ALIAS_DONE] = alias_on_q & ~alias_display_on;
    events[IRQ_WARN]       = power_off_warning & ~warn_q;
    events[IRQ_SAT]        = torque_sat_error & ~sat_q;
  end

  // Read clears status; a new event in the same cycle survives
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_status <= '0;
      irq        <= 1'b0;
    end else begin
      if (status_rd) begin
        irq_status <= events;
      end else begin
        irq_status <= irq_status | events;
      end
      // One cycle behind status, traded for a flop-driven pin
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule

/* core/sspb_pkg.sv */
// Constants, field layout and carrier types of the special-setup bank
package sspb_pkg;

  // Clock and tick timing
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned TICK_US      = 1000;
  localparam int unsigned TICK_CYCLES  = TICK_US * CLK_MHZ;

  // Register byte offsets
  localparam logic [11:0] OFF_LED_SEL     = 12'h000;
  localparam logic [11:0] OFF_ALIAS_TIME  = 12'h004;
  localparam logic [11:0] OFF_TQ_JUDGE    = 12'h00C;
  localparam logic [11:0] OFF_RSVD_FIRST  = 12'h010;
  localparam logic [11:0] OFF_RSVD_09     = 12'h024;
  localparam logic [11:0] OFF_RSVD_10     = 12'h028;
  localparam logic [11:0] OFF_RSVD_LAST   = 12'h034;
  localparam logic [11:0] OFF_WARN_TIME   = 12'h038;
  localparam logic [11:0] OFF_SAT_LIMIT   = 12'h040;
  localparam logic [11:0] OFF_EXT_ONE     = 12'h058;
  localparam logic [11:0] OFF_EXT_TWO     = 12'h05C;
  localparam logic [11:0] OFF_EXT_THREE   = 12'h060;
  localparam logic [11:0] OFF_IRQ_STATUS  = 12'h080;
  localparam logic [11:0] OFF_IRQ_MASK    = 12'h084;
  localparam logic [11:0] OFF_CONTROL     = 12'h088;
  localparam logic [11:0] OFF_STATE       = 12'h08C;

  // Fixed values of reserved parameters
  localparam logic [15:0] RSVD_ZERO_VAL   = 16'h0000;
  localparam logic [15:0] RSVD_09_VAL     = 16'h0168;
  localparam logic [15:0] RSVD_10_VAL     = 16'h0003;
  localparam logic [15:0] EXT_THREE_FIXED = 16'h0010;

  // Field positions
  localparam int unsigned EXT_TWO_DEV_BIT    = 14;
  localparam int unsigned EXT_THREE_SHUT_BIT = 0;
  localparam int unsigned CTRL_SAT_CLR_BIT   = 0;
  localparam int unsigned IRQ_ALIAS_DONE     = 0;
  localparam int unsigned IRQ_WARN           = 1;
  localparam int unsigned IRQ_SAT            = 2;
  localparam int unsigned IRQ_W              = 3;

  // Alias display timing in ms
  localparam int unsigned ALIAS_UNIT_MS  = 100;
  localparam int unsigned ALIAS_MIN_MS   = 600;
  localparam int unsigned ALIAS_MIN_SET  = ALIAS_MIN_MS / ALIAS_UNIT_MS;
  localparam int unsigned ALIAS_MAX_SET  = 1000;

  // Power-off warning settings
  localparam logic [15:0] WARN_MIN_SET   = 16'h000A;
  localparam logic [15:0] WARN_OFF_SET   = 16'h07D0;

  // Fieldbus state machine codes
  typedef enum logic [3:0] {
    SSPB_INIT              = 4'h1,
    SSPB_PRE_OPERATIONAL   = 4'h2,
    SSPB_BOOT              = 4'h3,
    SSPB_SAFE_OPERATIONAL  = 4'h4,
    SSPB_OPERATIONAL       = 4'h8
  } sspb_esm_type;

  typedef struct packed {
    logic torque_mode;
    logic limit_incl_cmd;
    logic limit_excl_cmd;
    logic sat_strobe;
    logic saturated;
    logic main_power_lost;
  } sspb_drive_type;

  typedef struct packed {
    logic [3:0] state;
    logic       link_down;
    logic       gen_out_cmd;
  } sspb_link_type;

endpackage

/* testbench/sspb_bank_sva.sv */
// Assertion checker for the special-setup bank
`timescale 1ns/1ps
module sspb_bank_sva
  import sspb_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  // Clock and reset
  input wire logic           clk,
  input wire logic           rstn,
  // APB
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [11:0]    paddr,
  input wire logic [31:0]    pwdata,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  // Drive and link
  input wire sspb_drive_type drive,
  input wire sspb_link_type  link,
  // Derived outputs
  input wire logic [14:0]    led_display_item,
  input wire logic           alias_display_on,
  input wire logic           torque_limit_active,
  input wire logic           power_off_warning,
  input wire logic           torque_sat_error,
  input wire logic           deviation_before_filter,
  input wire logic           fieldbus_general_output,
  input wire logic           irq
);
  logic        acc;
  logic [31:0] up_cnt;
  logic [31:0] lost_cnt;
  assign acc = psel && penable && pwrite && !pready;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Cycles since reset, for the alias floor
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) up_cnt <= 32'h0;
    else up_cnt <= up_cnt + 32'h1;
  end
  // Unbroken cycles of lost main power
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) lost_cnt <= 32'h0;
    else lost_cnt <= drive.main_power_lost ? lost_cnt + 32'h1 : 32'h0;
  end
  led_update_a: assert property ($changed(led_display_item) |->
    $past(acc && paddr == OFF_LED_SEL) ||
    $past(acc && paddr == OFF_LED_SEL, 2)) else $error("led item moved");
  alias_min_a: assert property ($fell(alias_display_on) |->
    up_cnt >= 600 * TICK_CYCLES_P) else $error("alias ended early");
  torque_off_a: assert property (!$past(drive.torque_mode) |->
    !torque_limit_active) else $error("torque out active");
  torque_on_a: assert property ($past(drive.torque_mode &&
    drive.limit_incl_cmd && drive.limit_excl_cmd) |->
    torque_limit_active) else $error("torque out idle");
  warn_time_a: assert property ($rose(power_off_warning) |->
    lost_cnt >= 8 * TICK_CYCLES_P) else $error("warning too soon");
  warn_restore_a: assert property (!drive.main_power_lost |=>
    !power_off_warning) else $error("warning kept");
  sat_cause_a: assert property ($rose(torque_sat_error) |->
    $past(drive.sat_strobe && drive.saturated)) else $error("sat error");
  dev_update_a: assert property ($changed(deviation_before_filter) |->
    $past(acc && paddr == OFF_EXT_TWO) ||
    $past(acc && paddr == OFF_EXT_TWO, 2)) else $error("dev sel moved");
  gen_follow_a: assert property (!$past(link.link_down) |->
    fieldbus_general_output == $past(link.gen_out_cmd))
    else $error("gen output wrong");
  cover property ($fell(alias_display_on));
  cover property ($rose(torque_sat_error));
  cover property ($rose(power_off_warning));
endmodule
bind sspb_bank sspb_bank_sva #(.TICK_CYCLES_P(TICK_CYCLES_P)) chk (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .drive(drive), .link(link),
  .led_display_item(led_display_item),
  .alias_display_on(alias_display_on),
  .torque_limit_active(torque_limit_active),
  .power_off_warning(power_off_warning),
  .torque_sat_error(torque_sat_error),
  .deviation_before_filter(deviation_before_filter),
  .fieldbus_general_output(fieldbus_general_output), .irq(irq));

/* testbench/sspb_bank_tb.sv */
// Self-checking testbench for the special-setup bank
`timescale 1ns/1ps
module sspb_bank_tb
  import sspb_pkg::*;
;
  localparam int unsigned TK = 10;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } sspb_row_type;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [14:0] led;
  logic alias_on, tq, warn, sat, dev, gen;
  sspb_drive_type drive;
  sspb_link_type link;
  int bad_count, checks_done, cyc, n;
  sspb_row_type rows [12] = '{
    '{OFF_LED_SEL, 32'h7FFF, 32'h7FFF}, '{OFF_ALIAS_TIME, 32'h0, 32'h0},
    '{OFF_TQ_JUDGE, 32'h1, 32'h1}, '{OFF_WARN_TIME, 32'h7D0, 32'h7D0},
    '{OFF_SAT_LIMIT, 32'h3, 32'h3}, '{OFF_EXT_ONE, 32'h0, 32'h0},
    '{OFF_EXT_TWO, 32'h4000, 32'h4000}, '{OFF_EXT_THREE, 32'h1, 32'h11},
    '{OFF_RSVD_09, 32'h168, 32'h168}, '{OFF_RSVD_10, 32'h3, 32'h3},
    '{OFF_RSVD_FIRST, 32'h0, 32'h0}, '{12'h0F0, 32'h5, 32'h0}};
  sspb_master m (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  sspb_bank #(.TICK_CYCLES_P(TK)) uut (.clk(clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drive(drive), .link(link), .led_display_item(led),
    .alias_display_on(alias_on), .torque_limit_active(tq),
    .power_off_warning(warn), .torque_sat_error(sat),
    .deviation_before_filter(dev), .fieldbus_general_output(gen),
    .irq(irq));
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= rstn ? cyc + 1 : 0;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    m.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic sat_pulse(input logic s);
    @(posedge clk);
    drive.sat_strobe <= 1'b1;
    drive.saturated <= s;
    @(posedge clk);
    drive.sat_strobe <= 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    cyc = 0;
    drive = '0;
    link = '0;
    tick(6);
    rstn <= 1'b1;
    tick(2);
    chk(alias_on, 1);
    m.xfer(1'b0, OFF_EXT_THREE, 32'h0, rd, er);
    chk(rd, 32'h10);
    wr(OFF_IRQ_MASK, 32'h1);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      m.xfer(1'b0, rows[i].a, 32'h0, rd, er);
      chk(rd, rows[i].e);
    end
    chk(er, 1);
    chk(led, 15'h7FFF);
    chk(dev, 1);
    for (n = 0; n < 4; n++) begin
      wr(OFF_TQ_JUDGE, n[1]);
      drive.torque_mode <= 1'b1;
      drive.limit_incl_cmd <= n[0];
      drive.limit_excl_cmd <= !n[0];
      tick(3);
      chk(tq, n[1] ? !n[0] : n[0]);
    end
    drive.limit_excl_cmd <= 1'b1;
    tick(3);
    chk(tq, 1);
    drive.torque_mode <= 1'b0;
    tick(3);
    chk(tq, 0);
    // Zero breaks the run, so four hits in five pulses give no error
    for (n = 0; n < 5; n++) sat_pulse(n != 2);
    tick(2);
    chk(sat, 0);
    sat_pulse(1'b1);
    tick(2);
    chk(sat, 1);
    wr(OFF_CONTROL, 32'h1);
    tick(2);
    chk(sat, 0);
    wr(OFF_SAT_LIMIT, 32'h0);
    for (n = 0; n < 5; n++) sat_pulse(1'b1);
    tick(2);
    chk(sat, 0);
    drive.main_power_lost <= 1'b1;
    tick(200);
    chk(warn, 0);
    wr(OFF_WARN_TIME, 32'hB);
    tick(85);
    chk(warn, 0);
    drive.main_power_lost <= 1'b0;
    tick(2);
    drive.main_power_lost <= 1'b1;
    tick(85);
    chk(warn, 0);
    tick(16);
    chk(warn, 1);
    chk(irq, 0);
    wr(OFF_WARN_TIME, 32'h9);
    tick(3);
    chk(warn, 0);
    drive.main_power_lost <= 1'b0;
    link.state <= SSPB_PRE_OPERATIONAL;
    link.gen_out_cmd <= 1'b1;
    link.link_down <= 1'b1;
    tick(3);
    chk(gen, 1);
    link.state <= SSPB_OPERATIONAL;
    link.link_down <= 1'b0;
    tick(3);
    link.link_down <= 1'b1;
    tick(3);
    chk(gen, 0);
    wr(OFF_EXT_THREE, 32'h10);
    link.link_down <= 1'b0;
    tick(3);
    link.link_down <= 1'b1;
    link.gen_out_cmd <= 1'b0;
    tick(3);
    chk(gen, 1);
    link.state <= SSPB_INIT;
    link.link_down <= 1'b0;
    tick(3);
    link.link_down <= 1'b1;
    link.gen_out_cmd <= 1'b1;
    tick(3);
    chk(gen, 1);
    link.state <= SSPB_SAFE_OPERATIONAL;
    link.link_down <= 1'b0;
    tick(3);
    link.link_down <= 1'b1;
    link.gen_out_cmd <= 1'b0;
    tick(3);
    chk(gen, 1);
    while (alias_on === 1'b1 && cyc < 9000) @(posedge clk);
    chk(cyc >= 6000 && cyc < 6020, 1);
    tick(2);
    chk(irq, 1);
    m.xfer(1'b0, OFF_IRQ_STATUS, 32'h0, rd, er);
    chk(rd, 32'h7);
    tick(2);
    chk(irq, 0);
    m.xfer(1'b0, OFF_IRQ_STATUS, 32'h0, rd, er);
    chk(rd, 32'h0);
    print_verdict();
  end
endmodule

/* testbench/sspb_master.sv */
// Configuring master model speaking APB to the bank
`timescale 1ns/1ps
module sspb_master
  import sspb_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // Only legal values leave this master
  function automatic logic [31:0] legal(input logic [11:0] a,
                                        input logic [31:0] d);
    logic [31:0] r;
    r = {16'h0000, d[15:0]};
    if (a == OFF_EXT_ONE) r = 32'h0;
    if (a == OFF_EXT_TWO) r = r & 32'h4000;
    // bits 1-3 zero, bit 4 one
    if (a == OFF_EXT_THREE) r = (r & 32'h1) | 32'h10;
    if (a >= OFF_RSVD_FIRST && a <= OFF_RSVD_LAST)
      r = a == OFF_RSVD_09 ? 32'h168 : (a == OFF_RSVD_10 ? 32'h3 : 32'h0);
    return r;
  endfunction
  // Entry edge first, so two calls never collide in one step
  task automatic xfer(input logic we, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= we;
    paddr <= a;
    pwdata <= legal(a, d);
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
